/* inc/cpc_defines.svh */
// Purpose: constants of the cell protection controller
// Assumes: 20 MHz core clock, AXI4-Lite register access
// Notes:   times in microseconds, cycle counts derived at the top
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH

// ============================================================
// register map
`define CPC_ADDR_PROT      8'h00
`define CPC_ADDR_STAT      8'h04
`define CPC_ADDR_CMD       8'h08
`define CPC_ADDR_CTRL      8'h60
`define CPC_ADDR_W         8

// ============================================================
// protection register fields
`define CPC_P_OV           7
`define CPC_P_UV           6
`define CPC_P_COC          5
`define CPC_P_DOC          4
`define CPC_P_CC           3
`define CPC_P_DC           2
`define CPC_P_CE           1
`define CPC_P_DE           0

// ============================================================
// control register fields
`define CPC_C_NEGATIVE_BLANKING_ENABLE         7
`define CPC_C_UNDERVOLTAGE_SLEEP_ENABLE         6
`define CPC_C_BUS_LOW_SLEEP_ENABLE         5
`define CPC_C_NET_ADDRESS_OPCODE_SELECT        4
`define CPC_C_IO_PIN_WAKE_SWITCH_ENABLE        2
`define CPC_C_DATA_PIN_WAKE_SWITCH_ENABLE         1
`define CPC_CTRL_NV_RESET  8'h00
`define CPC_CTRL_WMASK     8'hFE
`define CPC_OPC_RNA_0      8'h33
`define CPC_OPC_RNA_1      8'h39

// ============================================================
// status and command fields
`define CPC_S_UVF          0
`define CPC_S_SLEEP        1
`define CPC_CMD_COPY       0

// ============================================================
// timing
`define CPC_CLK_HZ         20000000
`define CPC_HZ_PER_MHZ     1000000
`define CPC_T_OVD_US       1000
`define CPC_T_UVD_US       1000
`define CPC_T_OCD_US       10000
`define CPC_T_SCD_US       100
`define CPC_T_SLEEP_US     2000000

// ============================================================
// bus answers
`define CPC_RESP_OKAY      2'h0
`define CPC_RESP_SLVERR    2'h2

`endif

/* inc/cpc_pkg.sv */
// Purpose: types of the cell protection controller
// Assumes: included after cpc_defines.svh
// Notes:   all state of the top except rst_sync_ff lives in cpc_state_t
package cpc_pkg;

	typedef enum logic {CPC_ACTIVE, CPC_SLEEP} cpc_mode_t;

	typedef struct packed {
		logic       awvalid;
		logic [7:0] awaddr;
		logic       wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       bready;
		logic       arvalid;
		logic [7:0] araddr;
		logic       rready;
	} cpc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} cpc_axi_rsp_t;

	typedef struct packed {
		logic over_ov;
		logic below_ce;
		logic below_uv;
		logic below_ov_rc;
		logic sns_below_coc;
		logic sns_above_doc;
		logic sns_above_sc;
		logic sns_dis_1p2mv;
		logic sns_neg_small;
		logic pls_below_det;
		logic pls_above_det;
		logic charger_present;
		logic data_pin;
		logic io_pin;
	} cpc_cmp_t;

	typedef struct packed {
		logic       charge_fet_drive;
		logic       discharge_fet_drive;
		logic       terminal_test_pulldown;
		logic       terminal_test_pullup;
		logic       recovery_charge_enable;
		logic       current_blank;
		logic       io_pin_wake_pullup;
		logic       data_pin_wake_pullup;
		logic       sleep_mode;
		logic [7:0] net_address_opcode;
	} cpc_drive_t;

	typedef struct packed {
		cpc_mode_t        mode;
		cpc_cmp_t         s1;
		cpc_cmp_t         s2;
		logic             dq_prev;
		logic             pio_prev;
		logic [4:0][31:0] cnt;
		logic [31:0]      stable_cnt;
		logic             ov;
		logic             uv;
		logic             charge_overcurrent_flag;
		logic             discharge_overcurrent_flag;
		logic             ov_flag;
		logic             coc_flag;
		logic             doc_flag;
		logic             status_undervoltage_flag;
		logic             ce;
		logic             de;
		logic [7:0]       ctrl;
		logic [7:0]       nv;
		cpc_drive_t       drv;
		logic             aw_got;
		logic [7:0]       aw_addr;
		logic             w_got;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
	} cpc_state_t;

endpackage

/* verilog/cpc_top.sv */
// Purpose: protection state, FET drive and register file of the cell protector
// Assumes: comparator results and pins arrive asynchronously
// Notes:   registers reached over AXI4-Lite, one aligned word each
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.svh"

module cpc_top #(
	parameter int unsigned OVD_CYC   = `CPC_T_OVD_US * (`CPC_CLK_HZ / `CPC_HZ_PER_MHZ),
	parameter int unsigned UVD_CYC   = `CPC_T_UVD_US * (`CPC_CLK_HZ / `CPC_HZ_PER_MHZ),
	parameter int unsigned OCD_CYC   = `CPC_T_OCD_US * (`CPC_CLK_HZ / `CPC_HZ_PER_MHZ),
	parameter int unsigned SCD_CYC   = `CPC_T_SCD_US * (`CPC_CLK_HZ / `CPC_HZ_PER_MHZ),
	parameter int unsigned SLEEP_CYC = `CPC_T_SLEEP_US * (`CPC_CLK_HZ / `CPC_HZ_PER_MHZ)
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire cpc_pkg::cpc_axi_req_t axi_req,
	output      cpc_pkg::cpc_axi_rsp_t axi_rsp,
	input  wire cpc_pkg::cpc_cmp_t     cmp_in,
	output      cpc_pkg::cpc_drive_t   drive
);

	// ============================================================
	// helpers
	localparam int unsigned Q_OV  = 0;
	localparam int unsigned Q_UV  = 1;
	localparam int unsigned Q_COC = 2;
	localparam int unsigned Q_DOC = 3;
	localparam int unsigned Q_SC  = 4;

	// saturating qualification counter
	function automatic logic [31:0] cpc_qualify(
		input logic        cond,
		input logic [31:0] cnt,
		input logic [31:0] lim
	);
		logic [31:0] r;
		r = 32'h0;
		if (cond) begin
			r = (cnt >= lim) ? lim : cnt + 32'h1;
		end
		return r;
	endfunction

	// register index: 0 prot, 1 status, 2 command, 3 control, 4 none
	function automatic logic [2:0] cpc_decode(input logic [7:0] addr);
		logic [2:0] r;
		case (addr)
			`CPC_ADDR_PROT: r = 3'h0;
			`CPC_ADDR_STAT: r = 3'h1;
			`CPC_ADDR_CMD:  r = 3'h2;
			`CPC_ADDR_CTRL: r = 3'h3;
			default:        r = 3'h4;
		endcase
		return r;
	endfunction

	// ============================================================
	// reset release
	logic [1:0] rst_sync_ff;
	logic       rst_int_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync_ff[1];

	// ============================================================
	// state
	cpc_pkg::cpc_state_t q_ff;
	cpc_pkg::cpc_state_t nxt_q;
	cpc_pkg::cpc_state_t rst_q;

	always_comb begin
		rst_q      = '0;
		rst_q.mode = cpc_pkg::CPC_ACTIVE;
		rst_q.ce   = 1'b1;
		rst_q.de   = 1'b1;
		rst_q.nv   = `CPC_CTRL_NV_RESET;
		rst_q.ctrl = `CPC_CTRL_NV_RESET;
		rst_q.drv.net_address_opcode = `CPC_OPC_RNA_0;
	end

	// ============================================================
	// next-state logic
	logic        active;
	logic        fire_ov;
	logic        fire_uv;
	logic        fire_coc;
	logic        fire_doc;
	logic        fire_sc;
	logic        stable_done;
	logic        go_sleep;
	logic        wake;
	logic        do_write;
	logic [2:0]  widx;
	logic [2:0]  ridx;
	logic [7:0]  wbyte;
	logic [7:0]  prot_rd;
	cpc_pkg::cpc_cmp_t c;

	always_comb begin
		nxt_q  = q_ff;
		c      = q_ff.s2;
		active = (q_ff.mode == cpc_pkg::CPC_ACTIVE);

		nxt_q.s1       = cmp_in;
		nxt_q.s2       = q_ff.s1;
		nxt_q.dq_prev  = c.data_pin;
		nxt_q.pio_prev = c.io_pin;

		// qualification counters, held at zero outside Active
		nxt_q.cnt[Q_OV]  = cpc_qualify(active && c.over_ov, q_ff.cnt[Q_OV], OVD_CYC);
		nxt_q.cnt[Q_UV]  = cpc_qualify(active && c.below_uv, q_ff.cnt[Q_UV], UVD_CYC);
		nxt_q.cnt[Q_COC] = cpc_qualify(active && c.sns_below_coc, q_ff.cnt[Q_COC], OCD_CYC);
		nxt_q.cnt[Q_DOC] = cpc_qualify(active && c.sns_above_doc, q_ff.cnt[Q_DOC], OCD_CYC);
		nxt_q.cnt[Q_SC]  = cpc_qualify(active && c.sns_above_sc, q_ff.cnt[Q_SC], SCD_CYC);
		fire_ov  = (nxt_q.cnt[Q_OV] == OVD_CYC) && (q_ff.cnt[Q_OV] != OVD_CYC);
		fire_uv  = (nxt_q.cnt[Q_UV] == UVD_CYC) && (q_ff.cnt[Q_UV] != UVD_CYC);
		fire_coc = (nxt_q.cnt[Q_COC] == OCD_CYC) && (q_ff.cnt[Q_COC] != OCD_CYC);
		fire_doc = (nxt_q.cnt[Q_DOC] == OCD_CYC) && (q_ff.cnt[Q_DOC] != OCD_CYC);
		fire_sc  = (nxt_q.cnt[Q_SC] == SCD_CYC) && (q_ff.cnt[Q_SC] != SCD_CYC);

		// data line static timer
		nxt_q.stable_cnt = cpc_qualify(active && (c.data_pin == q_ff.dq_prev), q_ff.stable_cnt, SLEEP_CYC);
		stable_done      = (q_ff.stable_cnt == SLEEP_CYC);

		// fault states: set on qualification, release by threshold
		if (fire_ov) begin
			nxt_q.ov = 1'b1;
		end else if (c.below_ce || (c.sns_dis_1p2mv && !c.over_ov)) begin
			nxt_q.ov = 1'b0;
		end
		if (fire_uv) begin
			nxt_q.uv = 1'b1;
		end else if (!c.below_uv) begin
			nxt_q.uv = 1'b0;
		end
		if (fire_coc) begin
			nxt_q.charge_overcurrent_flag = 1'b1;
		end else if (c.pls_below_det) begin
			nxt_q.charge_overcurrent_flag = 1'b0;
		end
		if (fire_doc || fire_sc) begin
			nxt_q.discharge_overcurrent_flag = 1'b1;
		end else if (c.pls_above_det) begin
			nxt_q.discharge_overcurrent_flag = 1'b0;
		end

		// power modes
		go_sleep = active && !c.charger_present && stable_done &&
			((q_ff.ctrl[`CPC_C_BUS_LOW_SLEEP_ENABLE] && !c.data_pin) ||
			 (q_ff.ctrl[`CPC_C_UNDERVOLTAGE_SLEEP_ENABLE] && q_ff.uv));
		wake = !active &&
			((c.charger_present && !c.below_uv) ||
			 (c.data_pin && !q_ff.dq_prev) ||
			 (q_ff.ctrl[`CPC_C_DATA_PIN_WAKE_SWITCH_ENABLE] && !c.data_pin && q_ff.dq_prev) ||
			 (q_ff.ctrl[`CPC_C_IO_PIN_WAKE_SWITCH_ENABLE] && !c.io_pin && q_ff.pio_prev));

		// ---------------- register bus ----------------
		if (axi_req.awvalid && axi_rsp.awready) begin
			nxt_q.aw_got  = 1'b1;
			nxt_q.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			nxt_q.w_got  = 1'b1;
			nxt_q.w_data = axi_req.wdata;
			nxt_q.w_strb = axi_req.wstrb;
		end
		if (q_ff.bvalid && axi_req.bready) begin
			nxt_q.bvalid = 1'b0;
		end
		do_write = q_ff.aw_got && q_ff.w_got && !q_ff.bvalid;
		widx     = cpc_decode(q_ff.aw_addr);
		wbyte    = q_ff.w_data[7:0];
		if (do_write) begin
			nxt_q.aw_got = 1'b0;
			nxt_q.w_got  = 1'b0;
			nxt_q.bvalid = 1'b1;
			nxt_q.bresp  = (widx == 3'h4) ? `CPC_RESP_SLVERR : `CPC_RESP_OKAY;
		end

		// flag clears by software first, hardware sets below win
		if (do_write && q_ff.w_strb[0]) begin
			case (widx)
				3'h0: begin
					if (!wbyte[`CPC_P_OV]) begin
						nxt_q.ov_flag = 1'b0;
					end
					if (!wbyte[`CPC_P_COC]) begin
						nxt_q.coc_flag = 1'b0;
					end
					if (!wbyte[`CPC_P_DOC]) begin
						nxt_q.doc_flag = 1'b0;
					end
					if (active) begin
						nxt_q.ce = wbyte[`CPC_P_CE];
						nxt_q.de = wbyte[`CPC_P_DE];
					end
				end
				3'h1: begin
					if (!wbyte[`CPC_S_UVF]) begin
						nxt_q.status_undervoltage_flag = 1'b0;
					end
				end
				3'h2: begin
					if (wbyte[`CPC_CMD_COPY]) begin
						nxt_q.nv = q_ff.ctrl;
					end
				end
				3'h3: begin
					nxt_q.ctrl = wbyte & `CPC_CTRL_WMASK;
				end
				default: begin
				end
			endcase
		end

		// sleep entry clears ov_flag, coc_flag and doc_flag, wake restores enables
		if (go_sleep) begin
			nxt_q.mode     = cpc_pkg::CPC_SLEEP;
			nxt_q.ov_flag  = 1'b0;
			nxt_q.coc_flag = 1'b0;
			nxt_q.doc_flag = 1'b0;
		end else if (wake) begin
			nxt_q.mode = cpc_pkg::CPC_ACTIVE;
			nxt_q.ce   = 1'b1;
			nxt_q.de   = 1'b1;
		end
		if (fire_ov) begin
			nxt_q.ov_flag = 1'b1;
		end
		if (fire_uv) begin
			nxt_q.status_undervoltage_flag = 1'b1;
		end
		if (fire_coc) begin
			nxt_q.coc_flag = 1'b1;
		end
		if (fire_doc || fire_sc) begin
			nxt_q.doc_flag = 1'b1;
		end

		// read channel
		ridx    = cpc_decode(axi_req.araddr);
		prot_rd = {q_ff.ov_flag, q_ff.status_undervoltage_flag, q_ff.coc_flag, q_ff.doc_flag,
			q_ff.drv.charge_fet_drive, q_ff.drv.discharge_fet_drive,
			q_ff.ce, q_ff.de};
		if (q_ff.rvalid && axi_req.rready) begin
			nxt_q.rvalid = 1'b0;
		end
		if (axi_req.arvalid && axi_rsp.arready) begin
			nxt_q.rvalid = 1'b1;
			nxt_q.rresp  = `CPC_RESP_OKAY;
			nxt_q.rdata  = 32'h0;
			case (ridx)
				3'h0: nxt_q.rdata[7:0] = prot_rd;
				3'h1: nxt_q.rdata[7:0] = {6'h0, !active, q_ff.status_undervoltage_flag};
				3'h2: nxt_q.rdata[7:0] = 8'h00;
				3'h3: nxt_q.rdata[7:0] = q_ff.ctrl;
				default: nxt_q.rresp   = `CPC_RESP_SLVERR;
			endcase
		end

		// ---------------- outputs ----------------
		nxt_q.drv.charge_fet_drive = (nxt_q.mode == cpc_pkg::CPC_ACTIVE) &&
			!nxt_q.ov && !nxt_q.uv && !nxt_q.charge_overcurrent_flag && nxt_q.ce;
		nxt_q.drv.discharge_fet_drive = (nxt_q.mode == cpc_pkg::CPC_ACTIVE) &&
			!nxt_q.uv && !nxt_q.charge_overcurrent_flag && !nxt_q.discharge_overcurrent_flag && nxt_q.de;
		nxt_q.drv.terminal_test_pulldown = nxt_q.charge_overcurrent_flag;
		nxt_q.drv.terminal_test_pullup   = nxt_q.discharge_overcurrent_flag;
		nxt_q.drv.recovery_charge_enable = c.below_ov_rc;
		nxt_q.drv.current_blank = q_ff.ctrl[`CPC_C_NEGATIVE_BLANKING_ENABLE] && c.sns_neg_small;
		nxt_q.drv.io_pin_wake_pullup   = !active && q_ff.ctrl[`CPC_C_IO_PIN_WAKE_SWITCH_ENABLE];
		nxt_q.drv.data_pin_wake_pullup = !active && q_ff.ctrl[`CPC_C_DATA_PIN_WAKE_SWITCH_ENABLE];
		nxt_q.drv.sleep_mode = (nxt_q.mode == cpc_pkg::CPC_SLEEP);
		nxt_q.drv.net_address_opcode = q_ff.ctrl[`CPC_C_NET_ADDRESS_OPCODE_SELECT] ?
			`CPC_OPC_RNA_1 : `CPC_OPC_RNA_0;
	end

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			q_ff <= rst_q;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ============================================================
	// ports
	always_comb begin
		axi_rsp         = '0;
		axi_rsp.awready = !q_ff.aw_got && !q_ff.bvalid;
		axi_rsp.wready  = !q_ff.w_got && !q_ff.bvalid;
		axi_rsp.bvalid  = q_ff.bvalid;
		axi_rsp.bresp   = q_ff.bresp;
		axi_rsp.arready = !q_ff.rvalid;
		axi_rsp.rvalid  = q_ff.rvalid;
		axi_rsp.rdata   = q_ff.rdata;
		axi_rsp.rresp   = q_ff.rresp;
	end

	assign drive = q_ff.drv;

endmodule // cpc_top

`default_nettype wire

/* tb/cpc_top_properties.sv */
// Purpose: port-level checks of the cell protection controller
// Assumes: single clock, rst_n active low
// Notes:   bound to cpc_top below
`timescale 1ns/1ps
`default_nettype none
module cpc_top_properties (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire cpc_pkg::cpc_axi_req_t axi_req,
	input wire cpc_pkg::cpc_axi_rsp_t axi_rsp,
	input wire cpc_pkg::cpc_cmp_t     cmp_in,
	input wire cpc_pkg::cpc_drive_t   drive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ============================================================
	// sequences
	sequence s_ar_taken;
		axi_req.arvalid && axi_rsp.arready && !axi_rsp.rvalid;
	endsequence
	sequence s_rd_answer;
		##1 axi_rsp.rvalid;
	endsequence
	// ============================================================
	// register bus
	chk_rd_answer: assert property (s_ar_taken |-> s_rd_answer)
		else $error("read answer late");
	chk_rd_once: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
		else $error("read answer repeated");
	chk_wr_once: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
		else $error("write answer repeated");
	chk_wr_refuse: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write taken during answer");
	// ============================================================
	// protection
	chk_opcode_sel: assert property (drive.net_address_opcode == 8'h33 || drive.net_address_opcode == 8'h39)
		else $error("bad net address opcode");
	chk_pulldown_off: assert property ($rose(drive.terminal_test_pulldown) |-> ##[0:2]
		(!drive.charge_fet_drive && !drive.discharge_fet_drive))
		else $error("fets on during charge overcurrent");
	chk_pullup_off: assert property ($rose(drive.terminal_test_pullup) |-> ##[0:2] !drive.discharge_fet_drive)
		else $error("discharge on during discharge fault");
	chk_sleep_off: assert property ($rose(drive.sleep_mode) |-> ##[0:2]
		(!drive.charge_fet_drive && !drive.discharge_fet_drive))
		else $error("fets on in sleep");
endmodule // cpc_top_properties
bind cpc_top cpc_top_properties u_props (.clk(clk), .rst_n(rst_n), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .cmp_in(cmp_in), .drive(drive));
`default_nettype wire

/* tb/cpc_pack_model.sv */
// Purpose: pack terminal with charger and load seen through test currents
// Assumes: terminal detect is a plain level compare
// Notes:   charger_on and load_on set by the bench
`timescale 1ns/1ps
`default_nettype none
module cpc_pack_model (
	input  wire logic test_pulldown,
	input  wire logic test_pullup,
	input  wire logic charger_on,
	input  wire logic load_on,
	output logic      below_det,
	output logic      above_det,
	output logic      charger_seen
);
	assign below_det    = test_pulldown & !charger_on;
	assign above_det    = test_pullup & !load_on;
	assign charger_seen = charger_on;
endmodule // cpc_pack_model
`default_nettype wire

/* tb/cell_protection_controller_tb.sv */
// Purpose: register and protection tests of cpc_top
// Assumes: shortened delay parameters
// Notes:   bus sampled at falling edge, driven after rising edge
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defines.svh"
module cell_protection_controller_tb;
	localparam int OVD = 8, UVD = 8, OCD = 12, SCD = 4, SLP = 16;
	logic                  clk, rst_n, chg_on, load_on, pdet, udet, cseen;
	cpc_pkg::cpc_axi_req_t req;
	cpc_pkg::cpc_axi_rsp_t rsp;
	cpc_pkg::cpc_cmp_t     cmp_tb, cmp;
	cpc_pkg::cpc_drive_t   drv;
	int                    err_count, checked, cyc, i;
	cpc_top #(.OVD_CYC(OVD), .UVD_CYC(UVD), .OCD_CYC(OCD), .SCD_CYC(SCD), .SLEEP_CYC(SLP)) dut (
		.clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp), .cmp_in(cmp), .drive(drv));
	cpc_pack_model u_pack (.test_pulldown(drv.terminal_test_pulldown), .test_pullup(drv.terminal_test_pullup),
		.charger_on(chg_on), .load_on(load_on), .below_det(pdet), .above_det(udet), .charger_seen(cseen));
	always_comb begin
		cmp = cmp_tb;
		cmp.pls_below_det = pdet;
		cmp.pls_above_det = udet;
		cmp.charger_present = cseen;
	end
	// ============================================================
	// helpers
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic fets(input int n, input logic [1:0] e);
		repeat (n) @(posedge clk);
		@(negedge clk);
		chk({30'h0, drv.charge_fet_drive, drv.discharge_fet_drive}, {30'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic at, wt, bt, ah, wh, bh;
		logic [1:0] r;
		at = 0; wt = 0; bt = 0;
		@(posedge clk);
		req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
		req.wdata <= {24'h0, d}; req.wstrb <= 4'h1; req.bready <= 1'b1;
		while (!bt) begin
			@(negedge clk);
			ah = rsp.awready & !at; wh = rsp.wready & !wt; bh = rsp.bvalid; r = rsp.bresp;
			@(posedge clk);
			if (ah) begin req.awvalid <= 1'b0; at = 1; end
			if (wh) begin req.wvalid <= 1'b0; wt = 1; end
			if (bh) begin req.bready <= 1'b0; bt = 1; end
		end
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		logic at, rt, ah, rh;
		logic [31:0] d;
		logic [1:0] r;
		at = 0; rt = 0;
		@(posedge clk);
		req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
		while (!rt) begin
			@(negedge clk);
			ah = rsp.arready & !at; rh = rsp.rvalid; d = rsp.rdata; r = rsp.rresp;
			@(posedge clk);
			if (ah) begin req.arvalid <= 1'b0; at = 1; end
			if (rh) begin req.rready <= 1'b0; rt = 1; end
		end
		chk(d, ev);
		chk({30'h0, r}, {30'h0, er});
	endtask
	// ============================================================
	// clock, reset, timeout
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_of_test();
		end
	end
	// ============================================================
	// tests
	initial begin
		rst_n = 0; req = '0; cmp_tb = '0; cmp_tb.data_pin = 1'b1;
		chg_on = 0; load_on = 0; err_count = 0; checked = 0; cyc = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`CPC_ADDR_PROT, 32'h0F, `CPC_RESP_OKAY);
		rd(`CPC_ADDR_CTRL, 32'h00, `CPC_RESP_OKAY);
		rd(8'h40, 32'h00, `CPC_RESP_SLVERR);
		$display("test reset done");
		wr(`CPC_ADDR_CTRL, 8'hF2, `CPC_RESP_OKAY);
		rd(`CPC_ADDR_CTRL, 32'hF2, `CPC_RESP_OKAY);
		cmp_tb.sns_neg_small <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(drv.net_address_opcode, `CPC_OPC_RNA_1);
		chk(drv.current_blank, 1);
		wr(`CPC_ADDR_CTRL, 8'h00, `CPC_RESP_OKAY);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(drv.net_address_opcode, `CPC_OPC_RNA_0);
		chk(drv.current_blank, 0);
		$display("test control done");
		@(posedge clk) cmp_tb.over_ov <= 1'b1;
		repeat (OVD - 4) @(posedge clk);
		cmp_tb.over_ov <= 1'b0;
		fets(OVD + 8, 2'b11);
		@(posedge clk) cmp_tb.over_ov <= 1'b1;
		fets(OVD + 8, 2'b01);
		rd(`CPC_ADDR_PROT, 32'h87, `CPC_RESP_OKAY);
		cmp_tb.over_ov <= 1'b0;
		cmp_tb.below_ce <= 1'b1;
		fets(8, 2'b11);
		rd(`CPC_ADDR_PROT, 32'h8F, `CPC_RESP_OKAY);
		cmp_tb.below_ce <= 1'b0;
		wr(`CPC_ADDR_PROT, 8'h03, `CPC_RESP_OKAY);
		rd(`CPC_ADDR_PROT, 32'h0F, `CPC_RESP_OKAY);
		$display("test overvoltage done");
		@(posedge clk) chg_on <= 1'b1;
		cmp_tb.sns_below_coc <= 1'b1;
		fets(OCD + 8, 2'b00);
		chk(drv.terminal_test_pulldown, 1);
		rd(`CPC_ADDR_PROT, 32'h23, `CPC_RESP_OKAY);
		cmp_tb.sns_below_coc <= 1'b0;
		fets(8, 2'b00);
		@(posedge clk) chg_on <= 1'b0;
		fets(8, 2'b11);
		wr(`CPC_ADDR_PROT, 8'h03, `CPC_RESP_OKAY);
		$display("test charge overcurrent done");
		for (i = 0; i < 2; i++) begin
			@(posedge clk) load_on <= 1'b1;
			cmp_tb.sns_above_sc <= (i == 0);
			cmp_tb.sns_above_doc <= (i == 1);
			fets((i == 0) ? SCD + 8 : OCD + 8, 2'b10);
			chk(drv.terminal_test_pullup, 1);
			wr(`CPC_ADDR_PROT, 8'hF3, `CPC_RESP_OKAY);
			rd(`CPC_ADDR_PROT, 32'h1B, `CPC_RESP_OKAY);
			cmp_tb.sns_above_sc <= 1'b0;
			cmp_tb.sns_above_doc <= 1'b0;
			fets(8, 2'b10);
			@(posedge clk) load_on <= 1'b0;
			fets(8, 2'b11);
			wr(`CPC_ADDR_PROT, 8'h03, `CPC_RESP_OKAY);
		end
		$display("test discharge faults done");
		for (i = 0; i < 3; i++) begin
			wr(`CPC_ADDR_PROT, i[7:0], `CPC_RESP_OKAY);
			fets(4, i[1:0]);
		end
		wr(`CPC_ADDR_PROT, 8'h03, `CPC_RESP_OKAY);
		$display("test enables done");
		cmp_tb.below_uv <= 1'b1;
		fets(UVD + 8, 2'b00);
		rd(`CPC_ADDR_PROT, 32'h43, `CPC_RESP_OKAY);
		rd(`CPC_ADDR_STAT, 32'h01, `CPC_RESP_OKAY);
		cmp_tb.below_uv <= 1'b0;
		fets(8, 2'b11);
		wr(`CPC_ADDR_STAT, 8'h00, `CPC_RESP_OKAY);
		rd(`CPC_ADDR_PROT, 32'h0F, `CPC_RESP_OKAY);
		$display("test undervoltage done");
		wr(`CPC_ADDR_CTRL, 8'h20, `CPC_RESP_OKAY);
		cmp_tb.data_pin <= 1'b0;
		fets(SLP + 12, 2'b00);
		chk(drv.sleep_mode, 1);
		@(posedge clk) cmp_tb.data_pin <= 1'b1;
		fets(8, 2'b11);
		chk(drv.sleep_mode, 0);
		rd(`CPC_ADDR_PROT, 32'h0F, `CPC_RESP_OKAY);
		$display("test sleep done");
		end_of_test();
	end
endmodule // cell_protection_controller_tb
`default_nettype wire
